// *** rtl/tc_channel_status.sv ***
// Timer channel status, compare values and interrupt mask logic
//
// Behaviour
// - Register B is read-only in capture mode, writable in waveform mode.
// - Register C is read/write, 16 bits, always readable live.
// - Overflow flag bit 0 sets on overflow, clears on status read.
// - Capture mode: bit 1 sets when A or B loaded twice unread.
// - Waveform mode: bits 2 and 3 set on A and B compare.
// - Bit 4 sets on C compare in any mode, clears on read.
// - Capture mode: bits 5 and 6 set on A and B loads.
// - Bit 7 sets on external trigger, clears on status read.
// - Status bit 16 shows live counter clock enable.
// - Bits 17 and 18 mirror line A and B pin levels in capture mode, drive levels in waveform mode.
// - Writing ones to enable register enables those interrupts.
// - Writing ones to disable register disables those interrupts.
// - Mask register shows which event interrupts are enabled.
// - Mode bit zero is capture mode, one is waveform mode.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module tc_channel_status #(
    parameter int VALUE_W = 16
) (
    input  wire logic               CLK_IN,
    input  wire logic               RST_B_IN,
    input  wire logic [7:0]         ADDR_IN,
    input  wire logic [31:0]        WDATA_IN,
    input  wire logic               WR_IN,
    input  wire logic               RD_IN,
    output logic      [31:0]        RDATA_OUT,
    input  wire logic               OVERFLOW_IN,
    input  wire logic               CMP_A_IN,
    input  wire logic               CMP_B_IN,
    input  wire logic               CMP_C_IN,
    input  wire logic               LOAD_A_IN,
    input  wire logic               LOAD_B_IN,
    input  wire logic [VALUE_W-1:0] CAPTURE_VALUE_IN,
    input  wire logic               TRIGGER_IN,
    input  wire logic               CLOCK_ON_IN,
    input  wire logic               LINE_A_PIN_IN,
    input  wire logic               LINE_B_PIN_IN,
    input  wire logic               LINE_A_DRIVE_IN,
    input  wire logic               LINE_B_DRIVE_IN,
    output logic                    WAVE_MODE_OUT,
    output logic      [VALUE_W-1:0] VALUE_A_OUT,
    output logic      [VALUE_W-1:0] VALUE_B_OUT,
    output logic      [VALUE_W-1:0] VALUE_C_OUT,
    output logic                    IRQ_OUT
);
    localparam int EC = tc_status_pkg::EVENT_COUNT;

    logic rst_meta_q;
    logic rst_b_q;
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rst_meta_q <= 1'b0;
            rst_b_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_b_q    <= rst_meta_q;
        end
    end

    // Pin levels cross into the clock domain before the status mirror
    logic line_a_sync;
    logic line_b_sync;
    tc_sync2 u_sync_a (
        .clk_in   (CLK_IN),
        .rst_b_in (rst_b_q),
        .d_in     (LINE_A_PIN_IN),
        .q_out    (line_a_sync)
    );
    tc_sync2 u_sync_b (
        .clk_in   (CLK_IN),
        .rst_b_in (rst_b_q),
        .d_in     (LINE_B_PIN_IN),
        .q_out    (line_b_sync)
    );

    logic               wave_q;
    logic               wave_d;
    logic [VALUE_W-1:0] val_a_q;
    logic [VALUE_W-1:0] val_a_d;
    logic [VALUE_W-1:0] val_b_q;
    logic [VALUE_W-1:0] val_b_d;
    logic [VALUE_W-1:0] val_c_q;
    logic [VALUE_W-1:0] val_c_d;
    logic [EC-1:0]      mask_q;
    logic [EC-1:0]      mask_d;
    logic               unread_a_q;
    logic               unread_a_d;
    logic               unread_b_q;
    logic               unread_b_d;
    logic [31:0]        rdata_d;
    logic               irq_d;
    logic [EC-1:0]      flags;
    logic [EC-1:0]      set_ev;
    logic [EC-1:0]      allow_ev;
    logic               wr_mode;
    logic               wr_a;
    logic               wr_b;
    logic               wr_c;
    logic               rd_status;
    logic               rd_a;
    logic               rd_b;
    logic               capture;
    logic               overrun_ev;

    assign capture   = (wave_q == tc_status_pkg::MODE_CAPTURE);
    assign wr_mode   = WR_IN && ADDR_IN == tc_status_pkg::OFF_MODE;
    assign wr_a      = WR_IN && ADDR_IN == tc_status_pkg::OFF_CAPTURE_A;
    assign wr_b      = WR_IN && ADDR_IN == tc_status_pkg::OFF_CAPTURE_B;
    assign wr_c      = WR_IN && ADDR_IN == tc_status_pkg::OFF_LIMIT_C;
    assign rd_status = RD_IN && ADDR_IN == tc_status_pkg::OFF_EVENTS;
    assign rd_a      = RD_IN && ADDR_IN == tc_status_pkg::OFF_CAPTURE_A;
    assign rd_b      = RD_IN && ADDR_IN == tc_status_pkg::OFF_CAPTURE_B;

    // A second load while the previous one is still unread is an overrun
    assign overrun_ev = (LOAD_A_IN && unread_a_q && !rd_a)
                     || (LOAD_B_IN && unread_b_q && !rd_b);

    always_comb begin
        set_ev   = '0;
        allow_ev = '1;
        set_ev[tc_status_pkg::BIT_OVERFLOW] = OVERFLOW_IN;
        set_ev[tc_status_pkg::BIT_OVERRUN]  = overrun_ev;
        set_ev[tc_status_pkg::BIT_CMP_A]    = CMP_A_IN;
        set_ev[tc_status_pkg::BIT_CMP_B]    = CMP_B_IN;
        set_ev[tc_status_pkg::BIT_CMP_C]    = CMP_C_IN;
        set_ev[tc_status_pkg::BIT_LOAD_A]   = LOAD_A_IN;
        set_ev[tc_status_pkg::BIT_LOAD_B]   = LOAD_B_IN;
        set_ev[tc_status_pkg::BIT_TRIGGER]  = TRIGGER_IN;
        allow_ev[tc_status_pkg::BIT_OVERRUN] = capture;
        allow_ev[tc_status_pkg::BIT_CMP_A]   = !capture;
        allow_ev[tc_status_pkg::BIT_CMP_B]   = !capture;
        allow_ev[tc_status_pkg::BIT_LOAD_A]  = capture;
        allow_ev[tc_status_pkg::BIT_LOAD_B]  = capture;
    end

    // Set wins over the read-clear so no event is lost
    for (genvar i = 0; i < EC; i++) begin : g_flag
        tc_event_flag u_flag (
            .clk_in   (CLK_IN),
            .rst_b_in (rst_b_q),
            .allow_in (allow_ev[i]),
            .set_in   (set_ev[i]),
            .clear_in (rd_status),
            .flag_out (flags[i])
        );
    end

    always_comb begin
        wave_d     = wave_q;
        val_a_d    = val_a_q;
        val_b_d    = val_b_q;
        val_c_d    = val_c_q;
        mask_d     = mask_q;
        unread_a_d = unread_a_q;
        unread_b_d = unread_b_q;
        if (wr_mode) begin
            wave_d = WDATA_IN[15];
        end
        if (rd_a) begin
            unread_a_d = 1'b0;
        end
        if (rd_b) begin
            unread_b_d = 1'b0;
        end
        if (capture) begin
            if (LOAD_A_IN) begin
                val_a_d    = CAPTURE_VALUE_IN;
                unread_a_d = 1'b1;
            end
            if (LOAD_B_IN) begin
                val_b_d    = CAPTURE_VALUE_IN;
                unread_b_d = 1'b1;
            end
        end else begin
            unread_a_d = 1'b0;
            unread_b_d = 1'b0;
            if (wr_a) begin
                val_a_d = WDATA_IN[VALUE_W-1:0];
            end
            if (wr_b) begin
                val_b_d = WDATA_IN[VALUE_W-1:0];
            end
        end
        if (wr_c) begin
            val_c_d = WDATA_IN[VALUE_W-1:0];
        end
        if (WR_IN && ADDR_IN == tc_status_pkg::OFF_IRQ_SET) begin
            mask_d = mask_q | WDATA_IN[EC-1:0];
        end
        if (WR_IN && ADDR_IN == tc_status_pkg::OFF_IRQ_CLEAR) begin
            mask_d = mask_q & ~WDATA_IN[EC-1:0];
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (RD_IN) begin
            case (ADDR_IN)
                tc_status_pkg::OFF_MODE: begin
                    rdata_d[15] = wave_q;
                end
                tc_status_pkg::OFF_CAPTURE_A: begin
                    rdata_d[VALUE_W-1:0] = val_a_q;
                end
                tc_status_pkg::OFF_CAPTURE_B: begin
                    rdata_d[VALUE_W-1:0] = val_b_q;
                end
                tc_status_pkg::OFF_LIMIT_C: begin
                    rdata_d[VALUE_W-1:0] = val_c_q;
                end
                tc_status_pkg::OFF_EVENTS: begin
                    // Gated here too, so a flag of the other mode reads
                    // zero even in the cycle right after a mode change
                    rdata_d[EC-1:0] = flags & allow_ev;
                    rdata_d[tc_status_pkg::BIT_CLOCK_ON] = CLOCK_ON_IN;
                    rdata_d[tc_status_pkg::BIT_LINE_A] =
                        capture ? line_a_sync : LINE_A_DRIVE_IN;
                    rdata_d[tc_status_pkg::BIT_LINE_B] =
                        capture ? line_b_sync : LINE_B_DRIVE_IN;
                end
                tc_status_pkg::OFF_IRQ_VIEW: begin
                    rdata_d[EC-1:0] = mask_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // Registered so the pin comes from a flop; it lags the flags one cycle
    assign irq_d = |(flags & allow_ev & mask_q);

    always_ff @(posedge CLK_IN or negedge rst_b_q) begin
        if (!rst_b_q) begin
            wave_q     <= tc_status_pkg::MODE_CAPTURE;
            val_a_q    <= tc_status_pkg::VALUE_RESET;
            val_b_q    <= tc_status_pkg::VALUE_RESET;
            val_c_q    <= tc_status_pkg::VALUE_RESET;
            mask_q     <= tc_status_pkg::EVENT_RESET;
            unread_a_q <= 1'b0;
            unread_b_q <= 1'b0;
            RDATA_OUT  <= 32'h0000_0000;
            IRQ_OUT    <= 1'b0;
        end else begin
            wave_q     <= wave_d;
            val_a_q    <= val_a_d;
            val_b_q    <= val_b_d;
            val_c_q    <= val_c_d;
            mask_q     <= mask_d;
            unread_a_q <= unread_a_d;
            unread_b_q <= unread_b_d;
            RDATA_OUT  <= rdata_d;
            IRQ_OUT    <= irq_d;
        end
    end

    assign WAVE_MODE_OUT = wave_q;
    assign VALUE_A_OUT   = val_a_q;
    assign VALUE_B_OUT   = val_b_q;
    assign VALUE_C_OUT   = val_c_q;
endmodule : tc_channel_status

// *** rtl/tc_status_pkg.sv ***
// Register offsets, field positions and reset values of the timer channel
package tc_status_pkg;
    localparam logic [7:0] OFF_CAPTURE_A  = 8'h14;
    localparam logic [7:0] OFF_CAPTURE_B  = 8'h18;
    localparam logic [7:0] OFF_LIMIT_C    = 8'h1C;
    localparam logic [7:0] OFF_EVENTS     = 8'h20;
    localparam logic [7:0] OFF_IRQ_SET    = 8'h24;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h28;
    localparam logic [7:0] OFF_IRQ_VIEW   = 8'h2C;
    localparam logic [7:0] OFF_MODE       = 8'h04;
    localparam int BIT_OVERFLOW   = 0;
    localparam int BIT_OVERRUN    = 1;
    localparam int BIT_CMP_A      = 2;
    localparam int BIT_CMP_B      = 3;
    localparam int BIT_CMP_C      = 4;
    localparam int BIT_LOAD_A     = 5;
    localparam int BIT_LOAD_B     = 6;
    localparam int BIT_TRIGGER    = 7;
    localparam int BIT_CLOCK_ON   = 16;
    localparam int BIT_LINE_A     = 17;
    localparam int BIT_LINE_B     = 18;
    localparam int EVENT_COUNT    = 8;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [7:0]  EVENT_RESET = 8'h00;
    localparam logic        MODE_CAPTURE = 1'b0;
    localparam logic        MODE_WAVE    = 1'b1;
endpackage : tc_status_pkg

// *** rtl/tc_sync2.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module tc_sync2 (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= 1'b0;
            q_out  <= 1'b0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : tc_sync2

// *** rtl/tc_event_flag.sv ***
// One sticky event flag: set wins over read-clear, gated by mode
`timescale 1ns/100ps
module tc_event_flag (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic allow_in,
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      flag_out
);
    logic flag_d;
    always_comb begin
        flag_d = flag_out;
        if (clear_in) begin
            flag_d = 1'b0;
        end
        if (set_in && allow_in) begin
            flag_d = 1'b1;
        end
        if (!allow_in) begin
            flag_d = 1'b0;
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_out <= 1'b0;
        end else begin
            flag_out <= flag_d;
        end
    end
endmodule : tc_event_flag

// *** tb/tc_core_model.sv ***
// Counter core and channel line model that feeds the status block
`timescale 1ns/100ps
module tc_core_model (
    input  wire logic        clk_in,
    output logic      [6:0]  event_out,
    output logic      [15:0] value_out,
    output logic      [4:0]  level_out
);
    initial begin
        event_out = 7'h00;
        value_out = 16'h0000;
        level_out = 5'h00;
    end
    // Events are one-cycle pulses; the value is garbled once the pulse ends
    task automatic fire(input logic [6:0] m, input logic [15:0] v);
        @(posedge clk_in);
        event_out <= m;
        value_out <= v;
        @(posedge clk_in);
        event_out <= 7'h00;
        value_out <= ~v;
    endtask : fire
    task automatic lines(input logic [4:0] l);
        @(posedge clk_in);
        level_out <= l;
    endtask : lines
endmodule : tc_core_model

// *** tb/tc_channel_status_props.sv ***
// Port-level assertions for the timer channel status block
`timescale 1ns/100ps
module tc_channel_status_props #(
    parameter int VALUE_W = 16
) (
    input  wire logic               CLK_IN,
    input  wire logic               RST_B_IN,
    input  wire logic [7:0]         ADDR_IN,
    input  wire logic [31:0]        WDATA_IN,
    input  wire logic               WR_IN,
    input  wire logic               RD_IN,
    input  wire logic [31:0]        RDATA_OUT,
    input  wire logic               OVERFLOW_IN,
    input  wire logic               LOAD_B_IN,
    input  wire logic               TRIGGER_IN,
    input  wire logic               CLOCK_ON_IN,
    input  wire logic               LINE_A_DRIVE_IN,
    input  wire logic               WAVE_MODE_OUT,
    input  wire logic [VALUE_W-1:0] VALUE_B_OUT,
    input  wire logic [VALUE_W-1:0] VALUE_C_OUT,
    input  wire logic               IRQ_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    wire logic sr_rd = RD_IN && ADDR_IN == 8'h20;
    wire logic b_wr  = WR_IN && ADDR_IN == 8'h18;
    // Shadow of the trigger flag: set by the event, cleared by a status read
    logic trig_seen_q;
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            trig_seen_q <= 1'b0;
        end else if (TRIGGER_IN) begin
            trig_seen_q <= 1'b1;
        end else if (sr_rd) begin
            trig_seen_q <= 1'b0;
        end
    end
    chk_trig_sets: assert property ((sr_rd && trig_seen_q) |=>
        RDATA_OUT[7]) else $error("trigger flag missing");
    chk_ovf_clears: assert property ((!OVERFLOW_IN throughout
        (sr_rd ##2 sr_rd)) |=> !RDATA_OUT[0])
        else $error("overflow flag not cleared by read");
    chk_c_live: assert property ((RD_IN && ADDR_IN == 8'h1C) |=>
        RDATA_OUT == 32'($past(VALUE_C_OUT))) else $error("c readback");
    chk_b_locked: assert property ((b_wr && !WAVE_MODE_OUT &&
        !LOAD_B_IN) |=> $stable(VALUE_B_OUT)) else $error("b written");
    chk_b_open: assert property ((b_wr && WAVE_MODE_OUT) |=>
        VALUE_B_OUT == $past(WDATA_IN[15:0])) else $error("b not written");
    chk_wave_gate: assert property ((sr_rd && WAVE_MODE_OUT) |=>
        RDATA_OUT[6:5] == 2'h0 && !RDATA_OUT[1]) else $error("load flags");
    chk_capt_gate: assert property ((sr_rd && !WAVE_MODE_OUT) |=>
        RDATA_OUT[3:2] == 2'h0) else $error("compare flags in capture");
    chk_clock_live: assert property (sr_rd |=>
        RDATA_OUT[16] == $past(CLOCK_ON_IN)) else $error("clock status");
    chk_drive_mirror: assert property ((sr_rd && WAVE_MODE_OUT) |=>
        RDATA_OUT[17] == $past(LINE_A_DRIVE_IN)) else $error("line a");
    chk_irq_off: assert property ((WR_IN && ADDR_IN == 8'h28 &&
        WDATA_IN[7:0] == 8'hFF ##1 !(WR_IN && ADDR_IN == 8'h24)) |=>
        !IRQ_OUT) else $error("irq stays after disable");
endmodule : tc_channel_status_props
bind tc_channel_status tc_channel_status_props #(.VALUE_W(VALUE_W)) props_inst (
    .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .OVERFLOW_IN(OVERFLOW_IN), .LOAD_B_IN(LOAD_B_IN),
    .TRIGGER_IN(TRIGGER_IN), .CLOCK_ON_IN(CLOCK_ON_IN),
    .LINE_A_DRIVE_IN(LINE_A_DRIVE_IN), .WAVE_MODE_OUT(WAVE_MODE_OUT),
    .VALUE_B_OUT(VALUE_B_OUT), .VALUE_C_OUT(VALUE_C_OUT), .IRQ_OUT(IRQ_OUT));

// *** tb/tc_channel_status_tb.sv ***
// Self-checking bench for the timer channel status block
`timescale 1ns/100ps
module tc_channel_status_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [6:0]  ev;
    logic [15:0] val;
    logic [4:0]  lv;
    logic        wave;
    logic        irq;
    logic [15:0] val_a;
    int          n_fail = 0;
    int          check_count = 0;
    always #2.5 clk = ~clk;
    tc_core_model tc_core_model_inst (.clk_in(clk), .event_out(ev),
        .value_out(val), .level_out(lv));
    tc_channel_status tc_channel_status_inst (.CLK_IN(clk), .RST_B_IN(rst_b),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .OVERFLOW_IN(ev[0]), .CMP_A_IN(ev[1]),
        .CMP_B_IN(ev[2]), .CMP_C_IN(ev[3]), .LOAD_A_IN(ev[4]),
        .LOAD_B_IN(ev[5]), .CAPTURE_VALUE_IN(val), .TRIGGER_IN(ev[6]),
        .CLOCK_ON_IN(lv[0]), .LINE_A_PIN_IN(lv[1]), .LINE_B_PIN_IN(lv[2]),
        .LINE_A_DRIVE_IN(lv[3]), .LINE_B_DRIVE_IN(lv[4]),
        .WAVE_MODE_OUT(wave), .VALUE_A_OUT(val_a), .VALUE_B_OUT(),
        .VALUE_C_OUT(), .IRQ_OUT(irq));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : rd_chk
    task automatic t_reset();
        rd_chk(8'h18, 32'h0000_0000, "reset b");
        rd_chk(8'h1C, 32'h0000_0000, "reset c");
        rd_chk(8'h2C, 32'h0000_0000, "reset mask");
        rd_chk(8'h08, 32'h0000_0000, "unmapped read");
        $display("test reset done");
    endtask : t_reset
    task automatic t_capture();
        tc_core_model_inst.lines(5'h02);
        tc_core_model_inst.fire(7'h10, 16'h00AA);
        // Second A load unread, B load, C compare, ignored A compare, overflow
        tc_core_model_inst.fire(7'h3B, 16'h0055);
        wr_reg(8'h18, 32'h0000_1234);
        rd_chk(8'h18, 32'h0000_0055, "b locked");
        rd_chk(8'h20, 32'h0002_0073, "capture flags");
        rd_chk(8'h20, 32'h0002_0000, "flags cleared");
        rd_chk(8'h14, 32'h0000_0055, "a captured");
        chk("a output", 32'h0000_0055, {16'h0, val_a});
        $display("test capture done");
    endtask : t_capture
    task automatic t_wave();
        wr_reg(8'h04, 32'h0000_8000);
        tc_core_model_inst.lines(5'h13);
        tc_core_model_inst.fire(7'h5E, 16'h0011);
        wr_reg(8'h18, 32'h0000_1234);
        rd_chk(8'h18, 32'h0000_1234, "b open");
        chk("wave mode", 32'h0000_0001, {31'h0, wave});
        wr_reg(8'h14, 32'h0000_2222);
        rd_chk(8'h14, 32'h0000_2222, "a open");
        wr_reg(8'h1C, 32'hFFFF_BEEF);
        rd_chk(8'h1C, 32'h0000_BEEF, "c value");
        rd_chk(8'h20, 32'h0005_009C, "wave flags");
        rd_chk(8'h20, 32'h0005_0000, "wave cleared");
        $display("test wave done");
    endtask : t_wave
    task automatic t_irq();
        wr_reg(8'h24, 32'h0000_00FF);
        rd_chk(8'h2C, 32'h0000_00FF, "mask set");
        wr_reg(8'h28, 32'h0000_000F);
        rd_chk(8'h2C, 32'h0000_00F0, "mask cleared");
        tc_core_model_inst.fire(7'h01, 16'h0000);
        repeat (3) @(posedge clk);
        #1;
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        tc_core_model_inst.fire(7'h40, 16'h0000);
        repeat (3) @(posedge clk);
        #1;
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        rd_chk(8'h20, 32'h0005_0081, "irq flags");
        repeat (2) @(posedge clk);
        #1;
        chk("irq after read", 32'h0000_0000, {31'h0, irq});
        tc_core_model_inst.fire(7'h40, 16'h0000);
        repeat (3) @(posedge clk);
        wr_reg(8'h28, 32'h0000_00FF);
        repeat (2) @(posedge clk);
        #1;
        chk("irq disabled", 32'h0000_0000, {31'h0, irq});
        $display("test irq done");
    endtask : t_irq
    // Reset in mid-run with an interrupt pending must clear all state
    task automatic t_rerun();
        wr_reg(8'h24, 32'h0000_0080);
        repeat (2) @(posedge clk);
        #1;
        chk("irq before reset", 32'h0000_0001, {31'h0, irq});
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("irq after reset", 32'h0000_0000, {31'h0, irq});
        chk("mode after reset", 32'h0000_0000, {31'h0, wave});
        rd_chk(8'h2C, 32'h0000_0000, "mask after reset");
        rd_chk(8'h1C, 32'h0000_0000, "c after reset");
        rd_chk(8'h04, 32'h0000_0000, "mode reg after reset");
        rd_chk(8'h20, 32'h0003_0000, "status after reset");
        $display("test rerun done");
    endtask : t_rerun
    task automatic conclude();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_capture();
        t_wave();
        t_irq();
        t_rerun();
        conclude();
    end
    // The tests need well under a thousand cycles
    initial begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule : tc_channel_status_tb
